// File: core/status_out_defines.svh
// constants for the drive status output block: timing, register map, field positions, reset values
`ifndef STATUS_OUT_DEFINES_SVH
`define STATUS_OUT_DEFINES_SVH

// clock and timing
`define CLK_FREQ_KHZ 25000
`define PWRON_DELAY_MS 4500
`define BLINK_HALF_MS 1000

// register byte offsets
`define OFS_CFG 5'h00
`define OFS_SETTLE 5'h04
`define OFS_FWD_CAP 5'h08
`define OFS_REV_CAP 5'h0C
`define OFS_STATUS 5'h10
`define OFS_IRQ_STAT 5'h14
`define OFS_IRQ_MASK 5'h18

// configuration register fields
`define CFG_FAULT_SEL_BIT 0
`define CFG_COMP_EN_BIT 1
`define CFG_CLUTCH_LSB 2
`define CFG_SMOOTH_LSB 4
`define CFG_W 6

// status register bits
`define ST_FAULT 0
`define ST_FAULT_CAUTION 1
`define ST_CAUTION 2
`define ST_READY 3
`define ST_SETTLED 4
`define ST_CLAMPED 5
`define ST_PROFILE 6
`define ST_OFFSET_DONE 7
`define ST_COUPLED 8
`define ST_RAMP 9
`define ST_POWERED 10
`define ST_W 11

// interrupt event bits
`define IRQ_ALARM 0
`define IRQ_WARN 1
`define IRQ_SETTLED 2
`define IRQ_CLAMP 3
`define IRQ_POWERED 4
`define IRQ_W 5

// reset values
`define CFG_RST 6'h00
`define SETTLE_RST 16'h0064
`define FWD_CAP_RST 16'h0FFF
`define REV_CAP_RST 16'h0FFF
`define IRQ_MASK_RST 5'h00
`define CLUTCH_OFF 2'h0
`define ZERO32 32'h00000000

`endif

// File: core/status_out_pkg.sv
// types shared by the drive status output block
package status_out_pkg;

  typedef logic [15:0] count16_t;

  typedef enum logic [1:0] {
    SMOOTH_DIRECT,
    SMOOTH_TIMECONST,
    SMOOTH_RSVD2,
    SMOOTH_RSVD3
  } smooth_e;

  typedef enum logic {
    PWR_DELAY,
    PWR_UP
  } pwr_e;

endpackage

// File: core/poweron_timer.sv
// one-shot timer that flags the end of the power-on delay
`timescale 1ns/1ps
module poweron_timer #(
  parameter int unsigned CYCLES = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // result
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic done_q;
  wire last = (cnt_q == CW'(CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      cnt_q <= cnt_q + CW'(1);
      done_q <= last;
    end
  end

  assign done = done_q;
endmodule

// File: core/blink_gen.sv
// square wave that toggles every half period while run is high, resting high otherwise
`timescale 1ns/1ps
module blink_gen #(
  parameter int unsigned HALF = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control and wave
  input wire logic run,
  output logic wave
);
  localparam int CW = $clog2(HALF + 1);

  logic [CW-1:0] cnt_q;
  logic wave_q;
  wire wrap = (cnt_q == CW'(HALF - 1));

  // restarting from high on every new run makes the first phase a full on-period
  always_ff @(posedge clk) begin
    if (!rstn || !run) begin
      cnt_q <= '0;
      wave_q <= 1'b1;
    end else if (wrap) begin
      cnt_q <= '0;
      wave_q <= !wave_q;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign wave = wave_q;
endmodule

// File: core/servo_status_output_logic.sv
// drive status outputs toward the host, with an avalon-mm register slave and a masked interrupt
//
// Function
// RL1: fault output goes off whenever an alarm is present.
// RL2: with no alarm, fault output turns on 4 to 5 s after power-up.
// RL3: with fault select set, a warning also turns fault output off.
// RL4: combined fault-or-caution output is off while an alarm is present.
// RL5: non-battery warning blinks combined output on and off about every second.
// RL6: with no alarm or warning, combined output turns on 4 to 5 s after power-up.
// RL7: caution output is on whenever a warning is present.
// RL8: with no warning, caution output goes off 4 to 5 s after power-up.
// RL9: ready output on only with servo-on and drive ready to operate.
// RL10: settled output on while following error lies within settle window.
// RL11: settled output can only turn on while servo-on is active.
// RL12: torque clamped output on when torque reaches forward, reverse or analog limit.
// RL13: profile mode output follows switching between cam and normal positioning control.
// RL14: offset done on when compensation enabled or none executing during cam control.
// RL15: coupling engaged follows clutch-on, always off when clutch control setting is 0.
// RL16: coupling ramp off for direct; for time constant on until clutch off and smoothed.
// RL17: all outputs are registered levels; delays and blink come from clock counters.
`timescale 1ns/1ps
`include "status_out_defines.svh"
module servo_status_output_logic
  import status_out_pkg::*;
#(
  parameter int unsigned PWRON_CYCLES = `PWRON_DELAY_MS * `CLK_FREQ_KHZ,
  parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_MS * `CLK_FREQ_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm register slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // interrupt
  output logic irq,
  // internal drive state
  input wire logic alarm_active,
  input wire logic warning_active,
  input wire logic battery_warning,
  input wire logic servo_on,
  input wire logic drive_ready,
  input wire logic signed [15:0] droop_pulses,
  input wire logic signed [15:0] torque_now,
  input wire logic [15:0] analog_torque_cap,
  input wire logic cam_control_active,
  input wire logic comp_executing,
  input wire logic clutch_on,
  input wire logic clutch_smoothing_busy,
  // discrete status outputs
  output logic fault_out,
  output logic fault_or_caution_out,
  output logic caution_out,
  output logic ready_out,
  output logic settled_out,
  output logic torque_clamped_out,
  output logic profile_mode_out,
  output logic profile_offset_done,
  output logic coupling_engaged,
  output logic coupling_ramp_active
);

  // helpers
  function automatic count16_t mag16(input logic signed [15:0] v);
    mag16 = v[15] ? count16_t'(-v) : count16_t'(v);
  endfunction

  // magnitude against a limit; a limit of zero reads as always reached
  function automatic logic at_cap(input count16_t mag, input count16_t cap);
    at_cap = (mag >= cap);
  endfunction

  function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] ofs);
    reg_hit = (addr[4:2] == ofs[4:2]);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    be_merge = res;
  endfunction

  // ---------------- power-on sequence and blink ----------------
  logic pwr_done;
  pwr_e pwr_q;
  pwr_e pwr_d;
  logic blink;

  // the timer stops once done, so the delay runs once per reset and never wraps
  poweron_timer #(
    .CYCLES(PWRON_CYCLES)
  ) u_pwron (
    .clk(clk),
    .rstn(rstn),
    .done(pwr_done)
  );

  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      PWR_DELAY: begin
        if (pwr_done) begin
          pwr_d = PWR_UP;
        end
      end
      PWR_UP: begin
        pwr_d = PWR_UP;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pwr_q <= PWR_DELAY;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  wire powered = (pwr_q == PWR_UP);
  // battery warning alone does not make the combined output blink
  wire blink_warn = warning_active && !battery_warning;

  blink_gen #(
    .HALF(BLINK_HALF_CYCLES)
  ) u_blink (
    .clk(clk),
    .rstn(rstn),
    .run(blink_warn), // [RL5]
    .wave(blink)
  );

  // ---------------- configuration registers ----------------
  logic [`CFG_W-1:0] cfg_q;
  count16_t settle_q;
  count16_t fwd_cap_q;
  count16_t rev_cap_q;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_mask_q;

  wire fault_sel = cfg_q[`CFG_FAULT_SEL_BIT];
  wire comp_en = cfg_q[`CFG_COMP_EN_BIT];
  wire [1:0] clutch_ctrl = cfg_q[`CFG_CLUTCH_LSB +: 2];
  wire smooth_e smooth_mode = smooth_e'(cfg_q[`CFG_SMOOTH_LSB +: 2]);

  // ---------------- status decode ----------------
  wire fault_off = alarm_active || (fault_sel && warning_active); // [RL1] [RL3]
  wire fault_d = powered && !fault_off; // [RL2]

  // during the delay the combined output stays off; afterwards alarm dominates, then blink
  wire fault_caution_d = powered && !alarm_active && (blink_warn ? blink : !warning_active); // [RL4] [RL5] [RL6]

  // caution reads on through the power-on delay and drops once up if no warning
  wire caution_d = warning_active || !powered; // [RL7] [RL8]

  wire ready_d = servo_on && drive_ready; // [RL9]

  wire in_window = (mag16(droop_pulses) <= settle_q); // [RL10]
  wire settled_d = servo_on && in_window; // [RL11]

  count16_t torque_mag;
  assign torque_mag = mag16(torque_now);
  wire fwd_hit = !torque_now[15] && at_cap(torque_mag, fwd_cap_q);
  wire rev_hit = torque_now[15] && at_cap(torque_mag, rev_cap_q);
  wire ana_hit = at_cap(torque_mag, analog_torque_cap);
  wire clamped_d = fwd_hit || rev_hit || ana_hit; // [RL12]

  wire profile_d = cam_control_active; // [RL13]
  wire offset_done_d = comp_en || (cam_control_active && !comp_executing); // [RL14]

  wire coupled_d = (clutch_ctrl != `CLUTCH_OFF) && clutch_on; // [RL15]

  // modes other than direct and time constant are treated as off
  wire ramp_d = (smooth_mode == SMOOTH_TIMECONST) && (clutch_on || clutch_smoothing_busy); // [RL16]

  // ---------------- registered outputs ----------------
  logic fault_q;
  logic fault_caution_q;
  logic caution_q;
  logic ready_q;
  logic settled_q;
  logic clamped_q;
  logic profile_q;
  logic offset_done_q;
  logic coupled_q;
  logic ramp_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fault_q <= 1'b0;
      fault_caution_q <= 1'b0;
      caution_q <= 1'b1;
      ready_q <= 1'b0;
      settled_q <= 1'b0;
      clamped_q <= 1'b0;
      profile_q <= 1'b0;
      offset_done_q <= 1'b0;
      coupled_q <= 1'b0;
      ramp_q <= 1'b0;
    end else begin
      fault_q <= fault_d; // [RL17]
      fault_caution_q <= fault_caution_d;
      caution_q <= caution_d;
      ready_q <= ready_d;
      settled_q <= settled_d;
      clamped_q <= clamped_d;
      profile_q <= profile_d;
      offset_done_q <= offset_done_d;
      coupled_q <= coupled_d;
      ramp_q <= ramp_d;
    end
  end

  assign fault_out = fault_q;
  assign fault_or_caution_out = fault_caution_q;
  assign caution_out = caution_q;
  assign ready_out = ready_q;
  assign settled_out = settled_q;
  assign torque_clamped_out = clamped_q;
  assign profile_mode_out = profile_q;
  assign profile_offset_done = offset_done_q;
  assign coupling_engaged = coupled_q;
  assign coupling_ramp_active = ramp_q;

  logic [`ST_W-1:0] status_vec;
  always_comb begin
    status_vec = '0;
    status_vec[`ST_FAULT] = fault_q;
    status_vec[`ST_FAULT_CAUTION] = fault_caution_q;
    status_vec[`ST_CAUTION] = caution_q;
    status_vec[`ST_READY] = ready_q;
    status_vec[`ST_SETTLED] = settled_q;
    status_vec[`ST_CLAMPED] = clamped_q;
    status_vec[`ST_PROFILE] = profile_q;
    status_vec[`ST_OFFSET_DONE] = offset_done_q;
    status_vec[`ST_COUPLED] = coupled_q;
    status_vec[`ST_RAMP] = ramp_q;
    status_vec[`ST_POWERED] = powered;
  end

  // ---------------- interrupt events ----------------
  // rising edges of the alarm and warning inputs, and of the settled, clamp and powered states as they are registered
  logic alarm_seen_q;
  logic warn_seen_q;
  logic [`IRQ_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[`IRQ_ALARM] = alarm_active && !alarm_seen_q;
    ev[`IRQ_WARN] = warning_active && !warn_seen_q;
    ev[`IRQ_SETTLED] = settled_d && !settled_q;
    ev[`IRQ_CLAMP] = clamped_d && !clamped_q;
    ev[`IRQ_POWERED] = (pwr_q == PWR_DELAY) && (pwr_d == PWR_UP);
  end

  // ---------------- avalon-mm slave ----------------
  // one wait cycle per access: read data sampled while waitrequest is high; writes taken and reads answered the cycle after, with waitrequest low
  logic wait_q;
  logic [31:0] rdata_q;
  logic irq_q;

  wire req = read || write;
  wire wr_acc = write && !wait_q;

  wire hit_cfg = reg_hit(address, `OFS_CFG);
  wire hit_settle = reg_hit(address, `OFS_SETTLE);
  wire hit_fwd = reg_hit(address, `OFS_FWD_CAP);
  wire hit_rev = reg_hit(address, `OFS_REV_CAP);
  wire hit_stat = reg_hit(address, `OFS_STATUS);
  wire hit_istat = reg_hit(address, `OFS_IRQ_STAT);
  wire hit_imask = reg_hit(address, `OFS_IRQ_MASK);

  // unmapped offsets read zero and ignore writes
  wire [31:0] rd_mux =
    hit_cfg ? 32'(cfg_q) :
    hit_settle ? 32'(settle_q) :
    hit_fwd ? 32'(fwd_cap_q) :
    hit_rev ? 32'(rev_cap_q) :
    hit_stat ? 32'(status_vec) :
    hit_istat ? 32'(irq_stat_q) :
    hit_imask ? 32'(irq_mask_q) : `ZERO32;

  wire [31:0] wr_word = be_merge(rd_mux, writedata, byteenable);
  // only the enabled byte lanes of the written word clear anything
  wire [31:0] w1c_word = be_merge(`ZERO32, writedata, byteenable);
  wire [`IRQ_W-1:0] w1c = (wr_acc && hit_istat) ? w1c_word[`IRQ_W-1:0] : '0;
  // a new event in the clearing cycle survives the clear
  wire [`IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~w1c) | ev;

  // waitrequest rests high, so a request is never answered in the cycle it first appears
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wait_q <= 1'b1;
      rdata_q <= `ZERO32;
    end else begin
      wait_q <= !(req && wait_q);
      if (read && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_q <= `CFG_RST;
      settle_q <= `SETTLE_RST;
      fwd_cap_q <= `FWD_CAP_RST;
      rev_cap_q <= `REV_CAP_RST;
      irq_mask_q <= `IRQ_MASK_RST;
    end else if (wr_acc) begin
      if (hit_cfg) cfg_q <= wr_word[`CFG_W-1:0];
      if (hit_settle) settle_q <= wr_word[15:0];
      if (hit_fwd) fwd_cap_q <= wr_word[15:0];
      if (hit_rev) rev_cap_q <= wr_word[15:0];
      if (hit_imask) irq_mask_q <= wr_word[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_stat_q <= '0;
      alarm_seen_q <= 1'b0;
      warn_seen_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      alarm_seen_q <= alarm_active;
      warn_seen_q <= warning_active;
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign irq = irq_q;

endmodule

// File: verification/status_out_props.sv
// checker for the drive status outputs, bound to the top module
`timescale 1ns/1ps
module status_out_props #(
  parameter int unsigned PWRON_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // drive state
  input wire logic alarm_active,
  input wire logic warning_active,
  input wire logic servo_on,
  input wire logic drive_ready,
  input wire logic signed [15:0] torque_now,
  input wire logic [15:0] analog_torque_cap,
  input wire logic cam_control_active,
  // status outputs
  input wire logic fault_out,
  input wire logic fault_or_caution_out,
  input wire logic caution_out,
  input wire logic ready_out,
  input wire logic settled_out,
  input wire logic torque_clamped_out,
  input wire logic profile_mode_out
);
  // cycles since reset release, saturating so it never wraps into the delay window again
  int unsigned up_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      up_q <= 0;
    end else if (up_q < PWRON_CYCLES + 8) begin
      up_q <= up_q + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_fault_alarm_off: assert property (alarm_active |=> !fault_out)
    else $error("fault output on during alarm");
  a_fault_held_early: assert property (up_q < PWRON_CYCLES |-> !fault_out)
    else $error("fault output on before power-on delay");
  a_outputs_up_late: assert property (up_q == PWRON_CYCLES + 4 && !$past(alarm_active) && !$past(warning_active)
    |-> fault_out && fault_or_caution_out) else $error("outputs not on after power-on delay");
  a_caution_early_on: assert property (up_q < PWRON_CYCLES |-> caution_out)
    else $error("caution output off during power-on delay");
  a_caution_warn_on: assert property (warning_active |=> caution_out)
    else $error("caution output off during warning");
  a_combined_alarm_off: assert property (alarm_active |=> !fault_or_caution_out)
    else $error("combined output on during alarm");
  a_ready_when_on: assert property (servo_on && drive_ready |=> ready_out)
    else $error("ready output off");
  a_servo_off_gate: assert property (!servo_on |=> !ready_out && !settled_out)
    else $error("ready or settled on without servo-on");
  a_clamp_analog: assert property (!torque_now[15] && {1'b0, torque_now[14:0]} >= analog_torque_cap
    |=> torque_clamped_out) else $error("clamp output off at analog cap");
  a_profile_follow: assert property (1'b1 |=> profile_mode_out == $past(cam_control_active))
    else $error("profile output does not follow cam control");
  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");
  c_alarm_drop: cover property ($fell(fault_out) && alarm_active);
  c_blink_rise: cover property ($rose(fault_or_caution_out) && warning_active);
  c_clamp_rise: cover property ($rose(torque_clamped_out));
endmodule

bind servo_status_output_logic status_out_props #(.PWRON_CYCLES(PWRON_CYCLES)) u_props (.clk, .rstn, .read,
  .write, .waitrequest, .alarm_active, .warning_active, .servo_on, .drive_ready, .torque_now, .analog_torque_cap,
  .cam_control_active, .fault_out, .fault_or_caution_out, .caution_out, .ready_out, .settled_out,
  .torque_clamped_out, .profile_mode_out);

// File: verification/host_plc_model.sv
// host input card model: samples the combined output each clock and counts its changes
`timescale 1ns/1ps
module host_plc_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // sampled output
  input wire logic fault_or_caution_out,
  // change count
  output int toggles
);
  logic last_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      toggles <= 0;
      last_q <= 1'b0;
    end else begin
      last_q <= fault_or_caution_out;
      if (last_q != fault_or_caution_out) begin
        toggles <= toggles + 1;
      end
    end
  end
endmodule

// File: verification/servo_status_output_logic_tb.sv
// self-checking bench for the drive status output block
`timescale 1ns/1ps
`include "status_out_defines.svh"
module servo_status_output_logic_tb;
  localparam int unsigned PWR = 20;
  localparam int unsigned HALF = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest, irq;
  logic alarm_active = 1'b0, warning_active = 1'b0, battery_warning = 1'b0, servo_on = 1'b0, drive_ready = 1'b0;
  logic cam_control_active = 1'b0, comp_executing = 1'b0, clutch_on = 1'b0, clutch_smoothing_busy = 1'b0;
  logic signed [15:0] droop_pulses = 16'h0000, torque_now = 16'h0000;
  logic [15:0] analog_torque_cap = 16'hFFFF;
  logic fault_out, fault_or_caution_out, caution_out, ready_out, settled_out, torque_clamped_out;
  logic profile_mode_out, profile_offset_done, coupling_engaged, coupling_ramp_active;
  int n_errors = 0;
  int n_tests = 0;
  int toggles;
  always #20 clk = ~clk;
  servo_status_output_logic #(.PWRON_CYCLES(PWR), .BLINK_HALF_CYCLES(HALF)) u_dut (.clk, .rstn, .address, .read,
    .write, .byteenable, .writedata, .readdata, .waitrequest, .irq, .alarm_active, .warning_active, .battery_warning,
    .servo_on, .drive_ready, .droop_pulses, .torque_now, .analog_torque_cap, .cam_control_active, .comp_executing,
    .clutch_on, .clutch_smoothing_busy, .fault_out, .fault_or_caution_out, .caution_out, .ready_out, .settled_out,
    .torque_clamped_out, .profile_mode_out, .profile_offset_done, .coupling_engaged, .coupling_ramp_active);
  host_plc_model u_host (.clk, .rstn, .fault_or_caution_out, .toggles);
  task finish_test;
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // request held until waitrequest is seen low at a rising edge; read data is taken at that same edge
  task bus(input logic we, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= we;
    read <= !we;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 4'hF, q);
    chk(nm, e, q);
  endtask
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task t_powerup;
    settle;
    chk("caution_out", 1, caution_out);
    chk("fault_out", 0, fault_out);
    repeat (PWR + 4) @(posedge clk);
    #1;
    chk("fault_out", 1, fault_out);
    chk("fault_or_caution_out", 1, fault_or_caution_out);
    chk("caution_out", 0, caution_out);
    rdc("status", `OFS_STATUS, 32'h00000403);
  endtask
  task t_regs;
    logic [31:0] q;
    rdc("cfg", `OFS_CFG, 32'h00000000);
    rdc("settle", `OFS_SETTLE, 32'h00000064);
    rdc("fwd_cap", `OFS_FWD_CAP, 32'h00000FFF);
    rdc("rev_cap", `OFS_REV_CAP, 32'h00000FFF);
    rdc("irq_mask", `OFS_IRQ_MASK, 32'h00000000);
    wr(5'h1C, 32'hFFFFFFFF);
    rdc("unmapped", 5'h1C, 32'h00000000);
    bus(1'b1, `OFS_SETTLE, 32'h00001234, 4'h1, q);
    rdc("settle byte", `OFS_SETTLE, 32'h00000034);
    wr(`OFS_SETTLE, 32'h00000064);
  endtask
  task t_alarm_irq;
    rdc("irq_stat", `OFS_IRQ_STAT, 32'h00000010);
    wr(`OFS_IRQ_STAT, 32'h0000001F);
    rdc("irq_stat", `OFS_IRQ_STAT, 32'h00000000);
    wr(`OFS_IRQ_MASK, 32'h00000001);
    @(posedge clk);
    alarm_active <= 1'b1;
    settle;
    chk("fault_out", 0, fault_out);
    chk("fault_or_caution_out", 0, fault_or_caution_out);
    chk("irq", 1, irq);
    wr(`OFS_IRQ_MASK, 32'h00000000);
    settle;
    chk("irq masked", 0, irq);
    wr(`OFS_IRQ_MASK, 32'h00000001);
    settle;
    chk("irq", 1, irq);
    wr(`OFS_IRQ_STAT, 32'h00000001);
    settle;
    chk("irq cleared", 0, irq);
    @(posedge clk);
    alarm_active <= 1'b0;
    settle;
    chk("fault_out", 1, fault_out);
  endtask
  task t_warning;
    int t0;
    wr(`OFS_CFG, 32'h00000001);
    warning_active <= 1'b1;
    settle;
    chk("fault_out sel", 0, fault_out);
    chk("caution_out", 1, caution_out);
    t0 = toggles;
    repeat (5 * HALF) @(posedge clk);
    #1;
    chk("blink toggles", 1, (toggles - t0 >= 4) && (toggles - t0 <= 6));
    wr(`OFS_CFG, 32'h00000000);
    battery_warning <= 1'b1;
    settle;
    chk("fault_out nosel", 1, fault_out);
    chk("fault_or_caution battery", 0, fault_or_caution_out);
    @(posedge clk);
    warning_active <= 1'b0;
    battery_warning <= 1'b0;
    settle;
    chk("caution_out", 0, caution_out);
    chk("fault_or_caution_out", 1, fault_or_caution_out);
  endtask
  task t_motion;
    logic signed [15:0] dv[4];
    logic signed [15:0] tv[5];
    dv = '{16'sd100, -16'sd100, 16'sd101, -16'sd101};
    tv = '{16'sh0200, 16'sh01FF, -16'sh0100, -16'sh00FF, 16'sh0010};
    @(posedge clk);
    drive_ready <= 1'b1;
    settle;
    chk("ready_out", 0, ready_out);
    chk("settled_out", 0, settled_out);
    @(posedge clk);
    servo_on <= 1'b1;
    settle;
    chk("ready_out", 1, ready_out);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      droop_pulses <= dv[i];
      settle;
      chk("settled_out", i < 2, settled_out);
    end
    wr(`OFS_FWD_CAP, 32'h00000200);
    wr(`OFS_REV_CAP, 32'h00000100);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      torque_now <= tv[i];
      analog_torque_cap <= (i == 4) ? 16'h0010 : 16'hFFFF;
      settle;
      chk("torque_clamped_out", i % 2 == 0, torque_clamped_out);
    end
    @(posedge clk);
    servo_on <= 1'b0;
    droop_pulses <= 16'sd0;
    torque_now <= 16'sd0;
    settle;
    // warning, settled and clamp rises since the alarm bit was cleared
    rdc("irq_stat events", `OFS_IRQ_STAT, 32'h0000000E);
  endtask
  task t_cam_clutch;
    @(posedge clk);
    cam_control_active <= 1'b1;
    clutch_on <= 1'b1;
    settle;
    chk("profile_mode_out", 1, profile_mode_out);
    chk("profile_offset_done", 1, profile_offset_done);
    chk("coupling_engaged off", 0, coupling_engaged);
    @(posedge clk);
    comp_executing <= 1'b1;
    settle;
    chk("profile_offset_done", 0, profile_offset_done);
    wr(`OFS_CFG, 32'h00000016);
    settle;
    chk("profile_offset_done en", 1, profile_offset_done);
    chk("coupling_engaged", 1, coupling_engaged);
    chk("coupling_ramp_active", 1, coupling_ramp_active);
    @(posedge clk);
    cam_control_active <= 1'b0;
    clutch_on <= 1'b0;
    clutch_smoothing_busy <= 1'b1;
    settle;
    chk("profile_mode_out", 0, profile_mode_out);
    chk("coupling_ramp smoothing", 1, coupling_ramp_active);
    @(posedge clk);
    clutch_smoothing_busy <= 1'b0;
    settle;
    chk("coupling_ramp done", 0, coupling_ramp_active);
    @(posedge clk);
    clutch_on <= 1'b1;
    wr(`OFS_CFG, 32'h00000004);
    settle;
    chk("coupling_ramp direct", 0, coupling_ramp_active);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_powerup();
    t_regs();
    t_alarm_irq();
    t_warning();
    t_motion();
    t_cam_clutch();
    finish_test();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule
